// File: logic/dip_core.sv
// dual-issue pairing check and branch prediction control
// Contract
// - issue at most two per clock; pair only two simple instructions
// - no pairing across register or flag write dependencies, explicit or implicit
// - displacement plus immediate instructions issue alone
// - prefixed instructions go u only, 0FH conditional jump exempt, enhanced exempts more
// - each prefix byte issues as a one-byte instruction; enhanced exempts 0FH
// - memory-destination ALU takes three clocks, memory-source two, both still simple
// - move, ALU, inc/dec, push, pop reg, lea, near branch, nop, test are simple
// - branches pair only as second instruction, never with the following one
// - shift or rotate by one, shift by immediate pair only as first
// - flag-setting ALU in u never pairs with carry-using op in v
// - compare then branch and push-push or pop-pop pairs are allowed
// - two paired memory ALU instructions add two clocks to three
// - paired results equal those of sequential execution
// - cache looked up with decode address; four-state predictor per entry
// - cache miss predicts not taken; correct prediction never stalls or flushes
// - near branches and calls execute in one clock, may pair
// - misprediction flushes both pipes; penalty three, or four for v conditional
// - fetch may run past segment limit; executing past it faults
// - never fetch from pages not present or not permitted
// - disable bit stops prediction; directory base load flushes the cache
// - enhanced lookup uses prefetch address over 16 bytes, four 4-way banks; the code has one direct-mapped 64-entry cache in both modes
// - v instruction is always the next sequential after u
// - prefixes issue to u one per clock, base pairs after them
module dip_core
    import dip_pkg::*;
#(
    parameter bit ENHANCED = 1'b0
) (
    input wire logic I_SYS_CLK, // core clock
    input wire logic I_SYS_RST, // sync reset, high
    input wire logic i_u_valid, // first candidate present
    input wire logic [3:0] i_u_class, // first candidate class
    input wire logic [7:0] i_u_prefix, // first candidate prefix byte, 0 if none
    input wire logic i_u_disp_imm, // first has disp and imm
    input wire logic i_u_mem_dst, // first writes memory via ALU
    input wire logic i_u_mem_src, // first reads memory via ALU
    input wire logic [REG_W-1:0] i_u_wr, // first write set, flags included
    input wire logic i_v_valid, // second candidate present
    input wire logic [3:0] i_v_class, // second candidate class
    input wire logic [7:0] i_v_prefix, // second prefix byte
    input wire logic i_v_disp_imm, // second has disp and imm
    input wire logic i_v_mem_dst, // second writes memory via ALU
    input wire logic [REG_W-1:0] i_v_rd, // second read set
    input wire logic [REG_W-1:0] i_v_wr, // second write set
    input wire logic [ADDR_W-1:0] i_lookup_addr, // decode or prefetch address
    input wire logic i_resolve, // branch resolved this clock
    input wire logic [ADDR_W-1:0] i_res_addr, // resolved branch address
    input wire logic i_res_taken, // actual direction
    input wire logic i_res_mispredict, // direction or target wrong
    input wire logic i_res_cond, // resolved branch is conditional
    input wire logic i_res_vpipe, // resolved in v pipe
    input wire logic i_exec_addr_ok, // next execution within segment limit
    input wire logic i_fetch_req, // prefetcher wants a code fetch
    input wire logic i_page_ok, // page present with rights
    input wire logic i_pred_disable, // prediction disable control, bit 0
    input wire logic i_dir_base_load, // directory base register loaded
    input wire logic i_burst_ready_n, // code fetch acknowledge pin
    output logic O_ISSUE_U, // u instruction issued
    output logic O_ISSUE_V, // v instruction paired
    output logic O_STALL, // decode held
    output logic O_FLUSH, // flush both pipes
    output logic O_PRED_HIT, // cache hit at lookup
    output logic O_PRED_TAKEN, // predicted taken
    output logic O_FETCH, // code fetch cycle started
    output logic O_FETCH_DONE, // code fetch acknowledged
    output logic O_GP_FAULT // segment limit fault
);
    typedef struct packed {
        dip_state_type state;
        logic [CNT_W-1:0] cnt;
        logic [BTC_ENTRIES-1:0] vld;
        logic [BTC_ENTRIES-1:0][TAG_W-1:0] tag;
        logic [BTC_ENTRIES-1:0][1:0] ctr;
        logic prev_branch;
        logic [1:0] rdy_sync;
        logic fetch_busy;
        logic issue_u; // u issue pulse
        logic issue_v; // v pairing pulse
        logic stall; // decode held
        logic flush; // flush pulse
        logic hit; // lookup hit
        logic taken; // predicted taken
        logic fetch; // fetch start pulse
        logic done; // fetch acknowledged
        logic gp; // limit fault pulse
    } dip_regs_type;

    dip_regs_type r, next_r;
    dip_class_type uc, vc;
    logic u_simple, v_simple, u_branch, v_branch, u_flagset, v_flagset;
    logic v_pfx_ok, u_pfx_sep, dep_ok, can_pair;
    logic [IDX_W-1:0] lk_idx, rs_idx;
    logic [TAG_W-1:0] lk_tag, rs_tag;
    logic lk_hit;
    logic [REG_W-1:0] flag_mask;

    assign uc = dip_class_type'(i_u_class);
    assign vc = dip_class_type'(i_v_class);
    assign flag_mask = {1'b1, {(REG_W-1){1'b0}}}; // top bit of a set is the flags

    // simple classes share one test; shift-by-one counts only in u
    function automatic logic is_simple(input dip_class_type c);
        case (c)
            CLS_MOV, CLS_ALU, CLS_INCDEC, CLS_PUSH, CLS_POP, CLS_LEA, CLS_JMP, CLS_JCC, CLS_CALL,
            CLS_NOP, CLS_TEST, CLS_CMP, CLS_ADCSBB: is_simple = 1'b1;
            default: is_simple = 1'b0;
        endcase
    endfunction : is_simple

    // pairing decision
    always_comb begin
        u_simple = is_simple(uc) || (uc == CLS_SHIFT1);
        v_simple = is_simple(vc);
        u_branch = (uc == CLS_JMP) || (uc == CLS_JCC) || (uc == CLS_CALL);
        v_branch = (vc == CLS_JMP) || (vc == CLS_JCC) || (vc == CLS_CALL);
        u_flagset = (uc == CLS_ALU) || (uc == CLS_CMP) || (uc == CLS_INCDEC) || (uc == CLS_SHIFT1);
        v_flagset = (vc == CLS_ADCSBB) || (vc == CLS_JCC);
        // enhanced decode folds these bytes into the opcode
        u_pfx_sep = (i_u_prefix != 8'h00) && !(ENHANCED && (i_u_prefix == PFX_0F));
        v_pfx_ok = (i_v_prefix == 8'h00) || ((i_v_prefix == PFX_0F) && (vc == CLS_JCC))
            || (ENHANCED && ((i_v_prefix == PFX_0F) || (i_v_prefix == PFX_66)
            || (i_v_prefix == PFX_67)));
        dep_ok = ((i_u_wr & (i_v_rd | i_v_wr) & ~flag_mask) == '0);
        if ((uc == CLS_PUSH && vc == CLS_PUSH) || (uc == CLS_POP && vc == CLS_POP)) begin
            dep_ok = 1'b1;
        end
        if (u_flagset && v_flagset && !(uc == CLS_CMP && vc == CLS_JCC)) begin
            dep_ok = 1'b0;
        end
        if ((i_u_wr & i_v_rd & flag_mask) != '0 && !(uc == CLS_CMP && v_branch)) begin
            dep_ok = 1'b0;
        end
        can_pair = i_u_valid && i_v_valid && u_simple && v_simple
            && !u_pfx_sep && (uc != CLS_PREFIX) && (vc != CLS_PREFIX)
            && !i_u_disp_imm && !i_v_disp_imm
            && v_pfx_ok && dep_ok
            && !u_branch && !r.prev_branch;
    end

    // cache lookup, one entry per line index
    // direct-mapped trades hit rate for a single tag compare per clock
    // lines that share an index evict each other; correctness is unaffected,
    // only the prediction quality drops
    assign lk_idx = i_lookup_addr[LINE_LSB +: IDX_W];
    assign lk_tag = i_lookup_addr[ADDR_W-1 -: TAG_W];
    assign rs_idx = i_res_addr[LINE_LSB +: IDX_W];
    assign rs_tag = i_res_addr[ADDR_W-1 -: TAG_W];
    assign lk_hit = r.vld[lk_idx] && (r.tag[lk_idx] == lk_tag);

    // next-state logic
    always_comb begin
        next_r = r;
        next_r.rdy_sync = {r.rdy_sync[0], ~i_burst_ready_n};
        next_r.issue_u = 1'b0;
        next_r.issue_v = 1'b0;
        next_r.flush = 1'b0;
        next_r.fetch = 1'b0;
        next_r.done = 1'b0;
        next_r.gp = 1'b0;
        next_r.hit = lk_hit && !i_pred_disable;
        next_r.taken = lk_hit && !i_pred_disable && r.ctr[lk_idx][1];
        // fetch only to accessible pages; completion waits for burst ready
        if (!r.fetch_busy && i_fetch_req && i_page_ok) begin
            next_r.fetch = 1'b1;
            next_r.fetch_busy = 1'b1;
        end else if (r.fetch_busy && r.rdy_sync[1]) begin
            next_r.fetch_busy = 1'b0;
            next_r.done = 1'b1;
        end
        case (r.state)
            ST_RUN: begin
                if (i_resolve && i_res_mispredict) begin
                    next_r.flush = 1'b1;
                    next_r.state = ST_FLUSH;
                    next_r.cnt = (i_res_cond && i_res_vpipe) ? PEN_V_COND
                        : (i_res_cond ? PEN_U_COND : PEN_UNCOND);
                end else if (i_u_valid && !i_exec_addr_ok) begin
                    next_r.gp = 1'b1;
                end else if (i_u_valid) begin
                    // one-clock branches and simple ops retire here
                    next_r.issue_u = 1'b1;
                    next_r.issue_v = can_pair;
                    next_r.prev_branch = can_pair ? v_branch : u_branch;
                    if (can_pair && (i_u_mem_dst || i_u_mem_src) && i_v_mem_dst) begin
                        next_r.state = ST_RMW;
                        next_r.cnt = RMW_MEM_DST_CLKS + RMW_PAIR_EXTRA - 3'h1;
                    end else if (i_u_mem_dst) begin
                        next_r.state = ST_RMW;
                        next_r.cnt = RMW_MEM_DST_CLKS - 3'h1;
                    end else if (i_u_mem_src) begin
                        next_r.state = ST_RMW;
                        next_r.cnt = RMW_MEM_SRC_CLKS - 3'h1;
                    end
                end
            end
            ST_RMW, ST_FLUSH: begin
                next_r.cnt = r.cnt - 3'h1;
                if (r.cnt == 3'h1) begin
                    next_r.state = ST_RUN;
                end
            end
            default: next_r.state = ST_RUN;
        endcase
        next_r.stall = (next_r.state != ST_RUN);
        // predictor update on resolution; a taken miss allocates
        if (i_resolve && !i_pred_disable) begin
            if (r.vld[rs_idx] && r.tag[rs_idx] == rs_tag) begin
                if (i_res_taken && r.ctr[rs_idx] != PRED_ST) begin
                    next_r.ctr[rs_idx] = r.ctr[rs_idx] + 2'h1;
                end else if (!i_res_taken && r.ctr[rs_idx] != PRED_SNT) begin
                    next_r.ctr[rs_idx] = r.ctr[rs_idx] - 2'h1;
                end
            end else if (i_res_taken) begin
                next_r.vld[rs_idx] = 1'b1;
                next_r.tag[rs_idx] = rs_tag;
                next_r.ctr[rs_idx] = PRED_WT;
            end
        end
        if (i_dir_base_load) begin
            next_r.vld = '0;
        end
    end

    // single state register; reset clears the cache valid bits and all pulses
    // counters and predictor bits are cleared as well, though they are dead while invalid
    always_ff @(posedge I_SYS_CLK) begin
        if (I_SYS_RST) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // outputs straight from the state register, no logic behind them
    // so every output changes only on the clock edge
    assign O_ISSUE_U = r.issue_u;
    assign O_ISSUE_V = r.issue_v;
    assign O_STALL = r.stall;
    assign O_FLUSH = r.flush;
    assign O_PRED_HIT = r.hit;
    assign O_PRED_TAKEN = r.taken;
    assign O_FETCH = r.fetch;
    assign O_FETCH_DONE = r.done;
    assign O_GP_FAULT = r.gp;

    // checks
    chk_pair_simple: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        can_pair |-> u_simple && v_simple) else $error("pair of non-simple instructions");
    chk_dispimm_single: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (i_u_disp_imm || i_v_disp_imm) |-> !can_pair) else $error("disp+imm paired");
    chk_v_needs_u: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        O_ISSUE_V |-> O_ISSUE_U) else $error("v issued without u");
    chk_branch_first: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (i_u_valid && u_branch) |-> !can_pair) else $error("branch paired as first");
    chk_flush_v_pen: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (r.state == ST_RUN && i_resolve && i_res_mispredict && i_res_cond && i_res_vpipe)
        |=> O_FLUSH ##0 O_STALL [*4] ##1 !O_STALL) else $error("v penalty not four");
    chk_flush_u_pen: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (r.state == ST_RUN && i_resolve && i_res_mispredict && !(i_res_cond && i_res_vpipe))
        |=> O_FLUSH ##0 O_STALL [*3] ##1 !O_STALL) else $error("penalty not three");
    chk_no_bad_fetch: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        O_FETCH |-> $past(i_page_ok)) else $error("fetch to inaccessible page");
    chk_pred_off: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $past(i_pred_disable) |-> !O_PRED_TAKEN) else $error("prediction while disabled");
    chk_cache_flush: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        i_dir_base_load |=> !O_PRED_HIT [*1] or !lk_hit) else $error("cache not flushed");
    chk_adc_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (uc == CLS_ALU && vc == CLS_ADCSBB) |-> !can_pair) else $error("alu paired with adc");
    cov_pair: cover property (@(posedge I_SYS_CLK) O_ISSUE_U && O_ISSUE_V);
    cov_flush: cover property (@(posedge I_SYS_CLK) O_FLUSH);
    cov_taken: cover property (@(posedge I_SYS_CLK) O_PRED_TAKEN);
    cov_fetch: cover property (@(posedge I_SYS_CLK) O_FETCH ##[1:20] O_FETCH_DONE);
    cov_rmw_pair: cover property (@(posedge I_SYS_CLK) O_ISSUE_V && O_STALL);

    // issue must stay quiet while a multi-clock op or a flush is counting
    chk_stall_quiet: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        r.state != ST_RUN
        |=> !O_ISSUE_U)
        else $error("issue during stall");

    // prefix checks
    chk_prefix_single: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (i_u_prefix != 8'h00 && !(ENHANCED && i_u_prefix == PFX_0F))
        |-> !can_pair)
        else $error("prefixed u paired");

    chk_v_prefix: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (!ENHANCED && i_v_prefix != 8'h00 && !(i_v_prefix == PFX_0F && vc == CLS_JCC))
        |-> !can_pair)
        else $error("prefixed v paired");

    // dependency and position checks
    chk_dep_block: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        ((i_u_wr & (i_v_rd | i_v_wr) & ~flag_mask) != '0 && !(uc == CLS_PUSH && vc == CLS_PUSH)
        && !(uc == CLS_POP && vc == CLS_POP)) |-> !can_pair)
        else $error("dependent pair issued");

    chk_shift_v: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        vc == CLS_SHIFT1
        |-> !can_pair)
        else $error("shift paired as second");

    chk_after_branch: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        r.prev_branch
        |-> !can_pair)
        else $error("paired after branch");

    // sequencing lengths
    chk_mem_dst_len: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (r.state == ST_RUN && !(i_resolve && i_res_mispredict) && i_u_valid && i_exec_addr_ok
        && i_u_mem_dst && !(can_pair && i_v_mem_dst)) |=> O_STALL ##1 O_STALL ##1 !O_STALL)
        else $error("mem destination length wrong");

    chk_rmw_pair_len: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (r.state == ST_RUN && !(i_resolve && i_res_mispredict) && i_u_valid && i_exec_addr_ok
        && can_pair && i_u_mem_dst && i_v_mem_dst) |=> O_STALL [*4] ##1 !O_STALL)
        else $error("paired rmw length wrong");

    // prediction checks
    chk_miss_not_taken: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !$past(lk_hit)
        |-> !O_PRED_TAKEN)
        else $error("miss predicted taken");

    chk_hit_off: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        $past(i_pred_disable)
        |-> !O_PRED_HIT)
        else $error("hit while disabled");

    // fault and fetch checks
    chk_gp_no_issue: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        O_GP_FAULT
        |-> !O_ISSUE_U)
        else $error("issued past limit");

    chk_one_fetch: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        O_FETCH
        |=> !O_FETCH)
        else $error("fetch started while busy");
endmodule : dip_core

// File: logic/dip_pkg.sv
// package for the dual-issue pairing and branch prediction block
package dip_pkg;
    // instruction classes as presented by the decoders
    typedef enum logic [3:0] {
        CLS_MOV     = 4'h0,
        CLS_ALU     = 4'h1,
        CLS_INCDEC  = 4'h2,
        CLS_PUSH    = 4'h3,
        CLS_POP     = 4'h4,
        CLS_LEA     = 4'h5,
        CLS_JMP     = 4'h6,
        CLS_JCC     = 4'h7,
        CLS_CALL    = 4'h8,
        CLS_NOP     = 4'h9,
        CLS_TEST    = 4'hA,
        CLS_SHIFT1  = 4'hB,
        CLS_CMP     = 4'hC,
        CLS_ADCSBB  = 4'hD,
        CLS_PREFIX  = 4'hE,
        CLS_COMPLEX = 4'hF
    } dip_class_type;

    // issue control states
    typedef enum logic [1:0] {
        ST_RUN   = 2'b00,
        ST_RMW   = 2'b01,
        ST_FLUSH = 2'b10
    } dip_state_type;

    localparam int ADDR_W = 32;
    localparam int REG_W = 16;
    localparam int CNT_W = 3;
    localparam int IDX_W = 6;
    localparam int BTC_ENTRIES = 64;
    localparam int BANKS = 4;
    localparam int WAYS = 4;
    localparam int LINE_BYTES = 16;
    localparam int LINE_LSB = 4;
    localparam int TAG_W = ADDR_W - IDX_W - LINE_LSB;
    localparam logic [7:0] PFX_0F = 8'h0F;
    localparam logic [7:0] PFX_66 = 8'h66;
    localparam logic [7:0] PFX_67 = 8'h67;
    localparam logic [1:0] PRED_SNT = 2'h0;
    localparam logic [1:0] PRED_WNT = 2'h1;
    localparam logic [1:0] PRED_WT = 2'h2;
    localparam logic [1:0] PRED_ST = 2'h3;
    localparam logic [CNT_W-1:0] RMW_MEM_DST_CLKS = 3'h3;
    localparam logic [CNT_W-1:0] RMW_MEM_SRC_CLKS = 3'h2;
    localparam logic [CNT_W-1:0] RMW_PAIR_EXTRA = 3'h2;
    localparam logic [CNT_W-1:0] PEN_UNCOND = 3'h3;
    localparam logic [CNT_W-1:0] PEN_U_COND = 3'h3;
    localparam logic [CNT_W-1:0] PEN_V_COND = 3'h4;
    localparam int SPEC_FETCH_BYTES = 100;
    localparam int PRED_DIS_BIT = 0;
endpackage : dip_pkg

// File: dv/dip_fetch_ack.sv
// system bus model that completes code fetch cycles
module dip_fetch_ack (
    input wire logic i_clk, // core clock
    input wire logic i_rst, // sync reset, high
    input wire logic i_fetch, // fetch cycle started
    input wire logic [3:0] i_delay, // wait before acknowledge
    output logic o_burst_ready_n // acknowledge, active low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    logic [3:0] cnt;
    // every fetch is acknowledged whatever the address; the pin idles high as if pulled up
    always @(posedge i_clk) begin
        if (i_rst) begin
            busy <= 1'b0;
            cnt <= 4'h0;
            o_burst_ready_n <= 1'b1;
        end else begin
            o_burst_ready_n <= 1'b1;
            if (busy) begin
                if (cnt == 4'h0) begin
                    o_burst_ready_n <= 1'b0;
                    busy <= 1'b0;
                end else begin
                    cnt <= cnt - 4'h1;
                end
            end else if (i_fetch) begin
                busy <= 1'b1;
                cnt <= i_delay;
            end
        end
    end
endmodule : dip_fetch_ack

// File: dv/dip_core_tb.sv
// self-checking bench for the pairing and prediction block
module dip_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dip_pkg::*;
    logic clk = 1'b0, rst = 1'b1, u_valid = 1'b0, v_valid = 1'b0, u_disp_imm = 1'b0, u_mem_dst = 1'b0;
    logic u_mem_src = 1'b0, v_disp_imm = 1'b0, v_mem_dst = 1'b0, resolve = 1'b0, res_taken = 1'b0;
    logic res_mis = 1'b0, res_cond = 1'b0, res_vpipe = 1'b0, exec_ok = 1'b1, fetch_req = 1'b0, page_ok = 1'b1;
    logic pred_dis = 1'b0, dir_load = 1'b0, burst_ready_n_n;
    logic [3:0] u_class = 4'h9, v_class = 4'h9, ack_delay = 4'h0;
    logic [7:0] u_prefix = 8'h00, v_prefix = 8'h00;
    logic [15:0] u_wr = 16'h0000, v_rd = 16'h0000, v_wr = 16'h0000;
    logic [31:0] look_addr = 32'h0, res_addr = 32'h0;
    logic issue_u, issue_v, stall, flush, hit, taken, fetch, fetch_done, gp;
    int bad_count = 0, checked = 0, cycles = 0;
    localparam logic [31:0] BR_A = 32'h0000_1230;

    always #2 clk = ~clk;

    dip_core i_dut (.I_SYS_CLK(clk), .I_SYS_RST(rst), .i_u_valid(u_valid), .i_u_class(u_class),
        .i_u_prefix(u_prefix), .i_u_disp_imm(u_disp_imm), .i_u_mem_dst(u_mem_dst), .i_u_mem_src(u_mem_src),
        .i_u_wr(u_wr), .i_v_valid(v_valid), .i_v_class(v_class), .i_v_prefix(v_prefix),
        .i_v_disp_imm(v_disp_imm), .i_v_mem_dst(v_mem_dst), .i_v_rd(v_rd), .i_v_wr(v_wr),
        .i_lookup_addr(look_addr), .i_resolve(resolve), .i_res_addr(res_addr), .i_res_taken(res_taken),
        .i_res_mispredict(res_mis), .i_res_cond(res_cond), .i_res_vpipe(res_vpipe), .i_exec_addr_ok(exec_ok),
        .i_fetch_req(fetch_req), .i_page_ok(page_ok), .i_pred_disable(pred_dis), .i_dir_base_load(dir_load),
        .i_burst_ready_n(burst_ready_n_n), .O_ISSUE_U(issue_u), .O_ISSUE_V(issue_v), .O_STALL(stall), .O_FLUSH(flush),
        .O_PRED_HIT(hit), .O_PRED_TAKEN(taken), .O_FETCH(fetch), .O_FETCH_DONE(fetch_done), .O_GP_FAULT(gp));

    dip_fetch_ack i_ack (.i_clk(clk), .i_rst(rst), .i_fetch(fetch), .i_delay(ack_delay), .o_burst_ready_n(burst_ready_n_n));

    task automatic test_done();
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : test_done

    // hang guard: the whole sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask : chk

    // present one candidate pair for a single edge, then judge the issue pulses
    task automatic pair(input logic [3:0] uc, vc, input logic [7:0] upx, input logic [15:0] uw, vr,
                        input logic udi, umd, vmd, eu, ev);
        @(posedge clk);
        u_class <= uc;
        v_class <= vc;
        u_prefix <= upx;
        u_wr <= uw;
        v_rd <= vr;
        u_disp_imm <= udi;
        u_mem_dst <= umd;
        v_mem_dst <= vmd;
        u_valid <= 1'b1;
        v_valid <= 1'b1;
        @(posedge clk);
        u_valid <= 1'b0;
        v_valid <= 1'b0;
        u_mem_dst <= 1'b0;
        v_mem_dst <= 1'b0;
        #1 chk({issue_u, issue_v}, {6'h0, eu, ev});
    endtask : pair

    // counts stall cycles from now over a fixed window longer than any penalty
    task automatic stalls(input logic [7:0] exp);
        logic [7:0] n;
        n = {7'h0, stall === 1'b1};
        repeat (9) begin
            @(posedge clk);
            #1 if (stall === 1'b1) n++;
        end
        chk(n, exp);
    endtask : stalls

    task automatic mispredict(input logic cond, vp, tk, input logic [7:0] pen);
        @(posedge clk);
        {resolve, res_mis, res_cond, res_vpipe, res_taken, res_addr} <= {2'b11, cond, vp, tk, BR_A};
        @(posedge clk);
        {resolve, res_mis} <= 2'b00;
        #1 chk({7'h0, flush}, 8'h01);
        stalls(pen);
    endtask : mispredict

    task automatic look(input logic [1:0] exp);
        @(posedge clk);
        look_addr <= BR_A;
        @(posedge clk);
        @(posedge clk);
        #1 chk({6'h0, hit, taken}, {6'h0, exp});
    endtask : look

    task automatic fetch_cycle(input logic pg, input logic [3:0] dly);
        int n;
        @(posedge clk);
        {fetch_req, page_ok, ack_delay} <= {1'b1, pg, dly};
        @(posedge clk);
        fetch_req <= 1'b0;
        n = 0;
        repeat (4) begin
            #1 if (fetch === 1'b1) n++;
            @(posedge clk);
        end
        chk(n[7:0], {7'h0, pg});
        n = 0;
        repeat (24) begin
            #1 if (fetch_done === 1'b1) n++;
            @(posedge clk);
        end
        chk(n[7:0], {7'h0, pg});
        page_ok <= 1'b1;
    endtask : fetch_cycle

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        pair(CLS_MOV, CLS_ALU, 8'h00, 16'h0001, 16'h0002, 0, 0, 0, 1, 1);
        pair(CLS_COMPLEX, CLS_MOV, 8'h00, 16'h0, 16'h0, 0, 0, 0, 1, 0);
        pair(CLS_MOV, CLS_ALU, 8'h00, 16'h0004, 16'h0004, 0, 0, 0, 1, 0);
        pair(CLS_MOV, CLS_ALU, 8'h00, 16'h0, 16'h0, 1, 0, 0, 1, 0);
        pair(CLS_MOV, CLS_ALU, PFX_66, 16'h0, 16'h0, 0, 0, 0, 1, 0);
        pair(CLS_SHIFT1, CLS_MOV, 8'h00, 16'h0, 16'h0, 0, 0, 0, 1, 1);
        pair(CLS_MOV, CLS_SHIFT1, 8'h00, 16'h0, 16'h0, 0, 0, 0, 1, 0);
        pair(CLS_ALU, CLS_ADCSBB, 8'h00, 16'h8000, 16'h8000, 0, 0, 0, 1, 0);
        pair(CLS_CMP, CLS_JCC, 8'h00, 16'h8000, 16'h8000, 0, 0, 0, 1, 1);
        pair(CLS_MOV, CLS_ALU, 8'h00, 16'h0, 16'h0, 0, 0, 0, 1, 0);
        pair(CLS_PUSH, CLS_PUSH, 8'h00, 16'h0010, 16'h0010, 0, 0, 0, 1, 1);
        pair(CLS_JMP, CLS_MOV, 8'h00, 16'h0, 16'h0, 0, 0, 0, 1, 0);
        pair(CLS_ALU, CLS_COMPLEX, 8'h00, 16'h0, 16'h0, 0, 1, 0, 1, 0);
        stalls(8'h02);
        pair(CLS_ALU, CLS_ALU, 8'h00, 16'h0001, 16'h0002, 0, 1, 1, 1, 1);
        stalls(8'h04);
        look(2'b00);
        mispredict(1'b1, 1'b0, 1'b1, 8'h03);
        look(2'b11);
        mispredict(1'b0, 1'b0, 1'b0, 8'h03);
        mispredict(1'b1, 1'b1, 1'b0, 8'h04);
        @(posedge clk);
        pred_dis <= 1'b1;
        look(2'b00);
        @(posedge clk);
        pred_dis <= 1'b0;
        dir_load <= 1'b1;
        @(posedge clk);
        dir_load <= 1'b0;
        look(2'b00);
        fetch_cycle(1'b1, 4'h0);
        fetch_cycle(1'b1, 4'h6);
        fetch_cycle(1'b0, 4'h0);
        @(posedge clk);
        exec_ok <= 1'b0;
        u_valid <= 1'b1;
        @(posedge clk);
        u_valid <= 1'b0;
        exec_ok <= 1'b1;
        begin
            int n;
            n = 0;
            repeat (4) begin
                #1 if (gp === 1'b1) n++;
                @(posedge clk);
            end
            chk(n[7:0], 8'h01);
        end
        test_done();
    end
endmodule : dip_core_tb
